// [verilog/cpu_bus_pkg.sv]
package cpu_bus_pkg;

   localparam int MEM_BYTES = 32768;
   localparam int PAGE_BYTES = 8192;
   localparam int ADDR_W = $clog2(MEM_BYTES);
   localparam int PAGE_ADDR_W = $clog2(PAGE_BYTES);
   localparam int STACK_DEPTH = 8;
   localparam int SP_W = 3;
   localparam int NUM_REGS = 7;
   localparam logic [2:0] BANK_OFFSET = 3'h3;

   // Upper status layout
   localparam int PSU_SP_LSB = 0;
   localparam int PSU_UF_LSB = 3;
   localparam int PSU_II = 5;
   localparam int PSU_FLAG = 6;
   localparam int PSU_SENSE = 7;
   // Lower status layout
   localparam int PSL_C = 0;
   localparam int PSL_COM = 1;
   localparam int PSL_OVF = 2;
   localparam int PSL_WC = 3;
   localparam int PSL_RS = 4;
   localparam int PSL_IDC = 5;
   localparam int PSL_CC_LSB = 6;

   localparam logic [1:0] CC_POSITIVE = 2'h1;
   localparam logic [1:0] CC_ZERO = 2'h0;
   localparam logic [1:0] CC_NEGATIVE = 2'h2;

   localparam logic [7:0] PSL_RESET = 8'h00;
   localparam logic [SP_W-1:0] SP_RESET = 3'h0;
   localparam logic [14:0] FETCH_RESET = 15'h0000;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_SETUP = 3'b010,
      BUS_WAIT = 3'b100
   } bus_state_t;

   // One external operation asked for by the core
   typedef struct packed {
      logic valid;
      logic write;
      logic is_io;
      logic io_ext;
      logic io_data;
      logic vector;
      logic last;
      logic [14:0] addr;
      logic [7:0] wdata;
   } bus_req_t;

   // Sequencing and status commands from the core
   typedef struct packed {
      logic instr_end;
      logic halt_exec;
      logic push;
      logic pop;
      logic [14:0] ret_addr;
      logic fetch_load;
      logic [14:0] fetch_value;
      logic psu_we;
      logic psl_we;
      logic [7:0] status_wdata;
   } core_ctl_t;

   typedef struct packed {
      logic we;
      logic carry;
      logic ovf;
      logic half;
      logic [7:0] result;
   } alu_upd_t;

   typedef struct packed {
      logic we;
      logic [1:0] sel;
      logic [7:0] wdata;
   } reg_acc_t;
endpackage

// [verilog/return_stack_mem.sv]
`timescale 1ns/100ps
module return_stack_mem
#(
   parameter int DEPTH = 8,
   parameter int WIDTH = 15
)
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic wr_en_in,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic rd_en_in,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
   output logic [WIDTH-1:0] rd_data_out
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   // Pointer wraps naturally only for a power-of-two depth
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("return_stack_mem depth must be a power of two");
   end

   // Storage has no reset; stale levels are never popped before a push
   always_ff @(posedge clk_in)
   begin
      if (wr_en_in)
      begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
   end

   // Registered read port
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         rd_data_out <= '0;
      end
      else if (rd_en_in)
      begin
         rd_data_out <= mem_q[rd_addr_in];
      end
   end
endmodule

// [verilog/cpu_bus_status.sv]
`timescale 1ns/100ps
module cpu_bus_status
   import cpu_bus_pkg::*;
#(
   parameter int ENHANCED = 1
)
(
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire bus_req_t BUS_REQ_IN,
   output logic BUS_READY_OUT,
   output logic BUS_DONE_OUT,
   output logic [7:0] BUS_RDATA_OUT,
   input wire core_ctl_t CORE_CTL_IN,
   input wire alu_upd_t ALU_UPD_IN,
   input wire reg_acc_t REG_ACC_IN,
   output logic [7:0] REG_RDATA_OUT,
   output logic [7:0] PSU_OUT,
   output logic [7:0] PSL_OUT,
   output logic [14:0] FETCH_PTR_OUT,
   output logic INTR_TAKE_OUT,
   output logic STALL_OUT,
   output logic [12:0] LOW_ADDRESS_LINES_OUT,
   output logic LOW_ADDRESS_OE_OUT,
   output logic PAGE_LOW_EXT_SELECT_OUT,
   output logic PAGE_HIGH_DATA_CTRL_OUT,
   output logic PAGE_OE_OUT,
   input wire logic [7:0] DATA_LINES_IN,
   output logic [7:0] DATA_LINES_OUT,
   output logic DATA_LINES_OE_OUT,
   output logic OPERATION_REQUEST_OUT,
   input wire logic OPERATION_ACKNOWLEDGE_N_IN,
   output logic MEMORY_OR_IO_SELECT_OUT,
   output logic READ_NOT_WRITE_OUT,
   output logic WRITE_STROBE_OUT,
   output logic CONTROL_OE_OUT,
   input wire logic ADDRESS_DRIVE_ENABLE_N_IN,
   input wire logic BUS_DRIVE_ENABLE_N_IN,
   input wire logic DATA_DRIVE_ENABLE_N_IN,
   output logic FINAL_CYCLE_MARKER_OUT,
   output logic SERIAL_OUT_LATCH_OUT,
   input wire logic SERIAL_IN_PIN_IN,
   input wire logic INTERRUPT_REQUEST_N_IN,
   output logic INTERRUPT_ACKNOWLEDGE_OUT,
   input wire logic SUSPEND_REQUEST_N_IN,
   output logic RUNNING_INDICATOR_OUT
);
   if (ENHANCED < 0 || ENHANCED > 1)
   begin : g_bad_variant
      $error("ENHANCED must be 0 or 1");
   end

   localparam logic II_RESET = (ENHANCED == 1);

   // Register zero stands alone; the other selects land in the chosen bank
   function automatic logic [2:0] reg_index(input logic [1:0] sel, input logic bank);
      logic [2:0] idx;
      idx = {1'b0, sel};
      if (sel != 2'h0 && bank)
      begin
         idx = idx + BANK_OFFSET;
      end
      return idx;
   endfunction

   function automatic logic [1:0] cc_of(input logic [7:0] r);
      if (r == 8'h00)
      begin
         return CC_ZERO;
      end
      else if (r[7])
      begin
         return CC_NEGATIVE;
      end
      return CC_POSITIVE;
   endfunction

   bus_state_t state_q;
   bus_req_t op_q;
   logic operation_request_q, wstrobe_q, interrupt_acknowledge_q, done_q, final_q;
   logic [7:0] rdata_q;
   logic [7:0] psl_q;
   logic [SP_W-1:0] sp_q;
   logic [1:0] uf_q;
   logic ii_q, flag_q, pause_q, halt_q, take_q, pop_pend_q;
   logic [14:0] fetch_q;
   logic [14:0] stack_rdata;
   logic [7:0] regs_q [NUM_REGS];
   logic boundary, accept, drive_data, bus_en;

   // New request only once the device has released its last acknowledge
   assign BUS_READY_OUT = (state_q == BUS_IDLE) && OPERATION_ACKNOWLEDGE_N_IN;

   // Bus sequencer: setup cycle, then request held until acknowledge
   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         state_q <= BUS_IDLE;
         op_q <= '0;
         operation_request_q <= 1'b0;
         wstrobe_q <= 1'b1;
         interrupt_acknowledge_q <= 1'b0;
         done_q <= 1'b0;
         final_q <= 1'b0;
         rdata_q <= 8'h00;
      end
      else
      begin
         done_q <= 1'b0;
         case (state_q)
            BUS_IDLE:
            begin
               if (BUS_REQ_IN.valid && OPERATION_ACKNOWLEDGE_N_IN)
               begin
                  op_q <= BUS_REQ_IN; // Held unchanged until done
                  wstrobe_q <= !BUS_REQ_IN.write;
                  final_q <= (ENHANCED == 1) && BUS_REQ_IN.last;
                  state_q <= BUS_SETUP;
               end
            end
            BUS_SETUP:
            begin
               operation_request_q <= 1'b1; // Outputs settled a cycle earlier
               interrupt_acknowledge_q <= op_q.vector;
               wstrobe_q <= 1'b1; // Write pulse opens
               state_q <= BUS_WAIT;
            end
            BUS_WAIT:
            begin
               if (op_q.write)
               begin
                  wstrobe_q <= 1'b0; // Single-cycle pulse
               end
               if (!OPERATION_ACKNOWLEDGE_N_IN) // Wait any length
               begin
                  operation_request_q <= 1'b0;
                  interrupt_acknowledge_q <= 1'b0;
                  wstrobe_q <= 1'b1;
                  final_q <= 1'b0;
                  done_q <= 1'b1;
                  rdata_q <= op_q.write ? rdata_q : DATA_LINES_IN;
                  state_q <= BUS_IDLE;
               end
            end
            default:
            begin
               state_q <= BUS_IDLE;
               operation_request_q <= 1'b0;
            end
         endcase
      end
   end

   // Address and line coding for memory, extended and plain I/O
   always_comb
   begin
      LOW_ADDRESS_LINES_OUT = op_q.addr[PAGE_ADDR_W-1:0];
      PAGE_LOW_EXT_SELECT_OUT = op_q.addr[PAGE_ADDR_W];
      PAGE_HIGH_DATA_CTRL_OUT = op_q.addr[PAGE_ADDR_W+1];
      if (op_q.is_io && op_q.io_ext)
      begin
         LOW_ADDRESS_LINES_OUT = {5'h00, op_q.addr[7:0]};
         PAGE_LOW_EXT_SELECT_OUT = 1'b1;
         PAGE_HIGH_DATA_CTRL_OUT = 1'b0;
      end
      else if (op_q.is_io)
      begin
         LOW_ADDRESS_LINES_OUT = 13'h0000;
         PAGE_LOW_EXT_SELECT_OUT = 1'b0;
         PAGE_HIGH_DATA_CTRL_OUT = op_q.io_data;
      end
   end

   assign MEMORY_OR_IO_SELECT_OUT = !op_q.is_io;
   assign READ_NOT_WRITE_OUT = !op_q.write;
   assign DATA_LINES_OUT = op_q.wdata;
   assign OPERATION_REQUEST_OUT = operation_request_q;
   assign WRITE_STROBE_OUT = wstrobe_q;
   assign INTERRUPT_ACKNOWLEDGE_OUT = interrupt_acknowledge_q;
   assign FINAL_CYCLE_MARKER_OUT = final_q;
   assign BUS_DONE_OUT = done_q;
   assign BUS_RDATA_OUT = rdata_q;

   // Drive enables; the variant decides which pin governs what
   assign drive_data = (state_q != BUS_IDLE) && op_q.write;
   assign bus_en = !BUS_DRIVE_ENABLE_N_IN;
   always_comb
   begin
      if (ENHANCED == 1)
      begin
         LOW_ADDRESS_OE_OUT = bus_en;
         PAGE_OE_OUT = bus_en;
         CONTROL_OE_OUT = bus_en;
         DATA_LINES_OE_OUT = bus_en && drive_data;
      end
      else
      begin
         LOW_ADDRESS_OE_OUT = !ADDRESS_DRIVE_ENABLE_N_IN;
         PAGE_OE_OUT = 1'b1;
         CONTROL_OE_OUT = 1'b1;
         DATA_LINES_OE_OUT = !DATA_DRIVE_ENABLE_N_IN && drive_data;
      end
   end

   // A halted core sits at a boundary; a suspended one takes nothing
   assign boundary = CORE_CTL_IN.instr_end || halt_q;
   assign accept = boundary && !INTERRUPT_REQUEST_N_IN && !ii_q
                   && !pause_q && SUSPEND_REQUEST_N_IN;

   // Suspend, halt and interrupt take-over
   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         pause_q <= 1'b0;
         halt_q <= 1'b0;
         take_q <= 1'b0;
      end
      else
      begin
         take_q <= accept; // Core then runs the zero-page call
         if (CORE_CTL_IN.instr_end && !SUSPEND_REQUEST_N_IN)
         begin
            pause_q <= 1'b1;
         end
         else if (SUSPEND_REQUEST_N_IN)
         begin
            pause_q <= 1'b0;
         end
         if (accept)
         begin
            halt_q <= 1'b0;
         end
         else if (CORE_CTL_IN.halt_exec)
         begin
            halt_q <= 1'b1;
         end
      end
   end

   assign INTR_TAKE_OUT = take_q;
   assign STALL_OUT = pause_q || halt_q;
   assign RUNNING_INDICATOR_OUT = !(pause_q || halt_q);

   // Upper status: hardware set of inhibit wins over a software load
   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         ii_q <= II_RESET;
         flag_q <= 1'b0;
         uf_q <= 2'h0;
         sp_q <= SP_RESET;
      end
      else
      begin
         if (accept)
         begin
            ii_q <= 1'b1;
         end
         else if (CORE_CTL_IN.psu_we)
         begin
            ii_q <= CORE_CTL_IN.status_wdata[PSU_II];
         end
         if (CORE_CTL_IN.psu_we)
         begin
            flag_q <= CORE_CTL_IN.status_wdata[PSU_FLAG];
            uf_q <= (ENHANCED == 1) ? CORE_CTL_IN.status_wdata[PSU_UF_LSB+:2] : 2'h0;
         end
         // Stack motion outranks a load of the pointer field
         if (CORE_CTL_IN.push)
         begin
            sp_q <= sp_q + 3'h1;
         end
         else if (CORE_CTL_IN.pop)
         begin
            sp_q <= sp_q - 3'h1;
         end
         else if (CORE_CTL_IN.psu_we)
         begin
            sp_q <= CORE_CTL_IN.status_wdata[PSU_SP_LSB+:SP_W];
         end
      end
   end

   assign SERIAL_OUT_LATCH_OUT = flag_q;
   assign PSU_OUT = {SERIAL_IN_PIN_IN, flag_q, ii_q, uf_q, sp_q};

   // Lower status: an explicit load beats the ALU update
   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         psl_q <= PSL_RESET;
      end
      else if (CORE_CTL_IN.psl_we)
      begin
         psl_q <= CORE_CTL_IN.status_wdata;
      end
      else if (ALU_UPD_IN.we)
      begin
         psl_q[PSL_C] <= ALU_UPD_IN.carry;
         psl_q[PSL_OVF] <= ALU_UPD_IN.ovf;
         psl_q[PSL_IDC] <= ALU_UPD_IN.half;
         psl_q[PSL_CC_LSB+:2] <= cc_of(ALU_UPD_IN.result);
      end
   end

   assign PSL_OUT = psl_q;

   // General registers, all but register zero banked by the select bit
   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         for (int i = 0; i < NUM_REGS; i++)
         begin
            regs_q[i] <= 8'h00;
         end
      end
      else if (REG_ACC_IN.we)
      begin
         regs_q[reg_index(REG_ACC_IN.sel, psl_q[PSL_RS])] <= REG_ACC_IN.wdata;
      end
   end

   assign REG_RDATA_OUT = regs_q[reg_index(REG_ACC_IN.sel, psl_q[PSL_RS])];

   return_stack_mem #(
      .DEPTH(STACK_DEPTH),
      .WIDTH(ADDR_W)
   ) u_stack (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .wr_en_in(CORE_CTL_IN.push),
      .wr_addr_in(sp_q + 3'h1),
      .wr_data_in(CORE_CTL_IN.ret_addr),
      .rd_en_in(CORE_CTL_IN.pop),
      .rd_addr_in(sp_q),
      .rd_data_out(stack_rdata)
   );

   // Fetch pointer; a pop lands one cycle later, after the stack read
   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         fetch_q <= FETCH_RESET;
         pop_pend_q <= 1'b0;
      end
      else
      begin
         pop_pend_q <= CORE_CTL_IN.pop;
         if (pop_pend_q)
         begin
            fetch_q <= stack_rdata;
         end
         else if (CORE_CTL_IN.fetch_load)
         begin
            fetch_q <= CORE_CTL_IN.fetch_value;
         end
      end
   end

   assign FETCH_PTR_OUT = fetch_q;

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);

   a_req_held: assert property (operation_request_q && OPERATION_ACKNOWLEDGE_N_IN |=> operation_request_q && $stable(op_q))
      else $error("request or bus fields changed before acknowledge");
   a_drop_after_ack: assert property ($fell(operation_request_q) |-> !$past(OPERATION_ACKNOWLEDGE_N_IN))
      else $error("request withdrawn without acknowledge");
   a_req_setup: assert property ($rose(operation_request_q) |-> $past(state_q) == BUS_SETUP)
      else $error("request rose without a setup cycle");
   a_read_strobe: assert property (operation_request_q && !op_q.write |-> wstrobe_q)
      else $error("write strobe low during read");
   a_write_pulse: assert property ($rose(operation_request_q) && op_q.write |-> wstrobe_q ##1 (!wstrobe_q || done_q))
      else $error("write pulse wrong width");
   a_ext_port: assert property (operation_request_q && op_q.is_io && op_q.io_ext |-> LOW_ADDRESS_LINES_OUT[12:8] == 5'h00 && PAGE_LOW_EXT_SELECT_OUT)
      else $error("extended port address badly placed");
   a_intr_gate: assert property (take_q |-> !$past(ii_q) && !$past(pause_q) && ii_q)
      else $error("interrupt taken while inhibited");
   a_pause_blocks: assert property (pause_q |=> !take_q)
      else $error("interrupt taken while suspended");
   a_pause_stops: assert property (CORE_CTL_IN.instr_end && !SUSPEND_REQUEST_N_IN |=> !RUNNING_INDICATOR_OUT)
      else $error("suspend did not stop the core");
   a_cc_code: assert property (ALU_UPD_IN.we && !CORE_CTL_IN.psl_we && ALU_UPD_IN.result == 8'h00 |=> psl_q[7:6] == CC_ZERO)
      else $error("zero result gave wrong condition code");
   a_pop_target: assert property (CORE_CTL_IN.push && !CORE_CTL_IN.pop ##1 CORE_CTL_IN.pop && !CORE_CTL_IN.push |=> ##1 fetch_q == $past(CORE_CTL_IN.ret_addr, 3))
      else $error("pop did not return the pushed address");

   c_write_done: cover property (op_q.write && done_q);
   c_read_done: cover property (!op_q.write && done_q);
   c_intr_taken: cover property (take_q);
   c_suspended: cover property (pause_q ##1 !pause_q);
endmodule

// [sim/bus_partner.sv]
`timescale 1ns/100ps
// Memory, I/O port and interrupting device on the far side of the bus
module bus_partner
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic req_in,
   input wire logic rnw_in,
   input wire logic interrupt_acknowledge_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic drive_in,
   input wire logic [3:0] delay_in,
   input wire logic [7:0] vector_in,
   output logic ack_n_out,
   output logic [7:0] lines_out
);
   logic [7:0] mem_q [256];
   logic [3:0] cnt_q;
   logic [7:0] last_q;
   logic [7:0] rd_val;
   // Undriven lines flip each cycle so that stale data can never pass for a read
   assign rd_val = interrupt_acknowledge_in ? vector_in : mem_q[addr_in];
   assign lines_out = drive_in ? wdata_in : ((req_in && rnw_in) ? rd_val : ~last_q);
   // Acknowledge after a chosen delay, held low until the request is withdrawn
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         ack_n_out <= 1'b1;
         cnt_q <= 4'h0;
      end
      else if (!req_in)
      begin
         ack_n_out <= 1'b1;
         cnt_q <= 4'h0;
      end
      else if (ack_n_out && cnt_q == delay_in)
      begin
         ack_n_out <= 1'b0;
         if (!rnw_in)
            mem_q[addr_in] <= wdata_in;
      end
      else if (ack_n_out)
         cnt_q <= cnt_q + 4'h1;
   end
   // Remember what the lines showed last
   always_ff @(posedge clk_in)
      last_q <= lines_out;
endmodule

// [sim/test_cpu_bus_status.sv]
`timescale 1ns/100ps
// Self-checking bench for the bus, run control and status block
module test_cpu_bus_status
   import cpu_bus_pkg::*;
;
   localparam logic [5:0] K_END = 6'h01;
   localparam logic [5:0] K_HALT = 6'h02;
   localparam logic [5:0] K_PUSH = 6'h04;
   localparam logic [5:0] K_POP = 6'h08;
   localparam logic [5:0] K_UP = 6'h10;
   localparam logic [5:0] K_LO = 6'h20;
   logic clk, rst_b, ack_n, bus_en_n, adr_en_n, dat_en_n, sense, irq_n, susp_n;
   bus_req_t req;
   core_ctl_t ctl;
   alu_upd_t alu;
   reg_acc_t racc;
   logic [7:0] dlines, vec, rdata, rreg, program_status_upper, program_status_lower, dout, psu0;
   logic [3:0] dly;
   logic [14:0] fptr;
   logic [12:0] lo;
   logic rdy, done, itake, lo_oe, page_lo, page_hi, page_oe, doe, operation_request, mio, rnw;
   logic wstb, ctl_oe, fcm, sol, interrupt_acknowledge, run, stall, lo_oe0, doe0;
   int n_errors, checks_done, n_take, k;

   cpu_bus_status DUT (.CLK_IN(clk), .RST_B_IN(rst_b), .BUS_REQ_IN(req),
      .BUS_READY_OUT(rdy), .BUS_DONE_OUT(done), .BUS_RDATA_OUT(rdata), .CORE_CTL_IN(ctl),
      .ALU_UPD_IN(alu), .REG_ACC_IN(racc), .REG_RDATA_OUT(rreg), .PSU_OUT(program_status_upper),
      .PSL_OUT(program_status_lower), .FETCH_PTR_OUT(fptr), .INTR_TAKE_OUT(itake), .STALL_OUT(stall),
      .LOW_ADDRESS_LINES_OUT(lo), .LOW_ADDRESS_OE_OUT(lo_oe),
      .PAGE_LOW_EXT_SELECT_OUT(page_lo), .PAGE_HIGH_DATA_CTRL_OUT(page_hi),
      .PAGE_OE_OUT(page_oe), .DATA_LINES_IN(dlines), .DATA_LINES_OUT(dout),
      .DATA_LINES_OE_OUT(doe), .OPERATION_REQUEST_OUT(operation_request),
      .OPERATION_ACKNOWLEDGE_N_IN(ack_n), .MEMORY_OR_IO_SELECT_OUT(mio),
      .READ_NOT_WRITE_OUT(rnw), .WRITE_STROBE_OUT(wstb), .CONTROL_OE_OUT(ctl_oe),
      .ADDRESS_DRIVE_ENABLE_N_IN(adr_en_n), .BUS_DRIVE_ENABLE_N_IN(bus_en_n),
      .DATA_DRIVE_ENABLE_N_IN(dat_en_n), .FINAL_CYCLE_MARKER_OUT(fcm),
      .SERIAL_OUT_LATCH_OUT(sol), .SERIAL_IN_PIN_IN(sense),
      .INTERRUPT_REQUEST_N_IN(irq_n), .INTERRUPT_ACKNOWLEDGE_OUT(interrupt_acknowledge),
      .SUSPEND_REQUEST_N_IN(susp_n), .RUNNING_INDICATOR_OUT(run));

   bus_partner far_end (.clk_in(clk), .rst_b_in(rst_b), .req_in(operation_request), .rnw_in(rnw),
      .interrupt_acknowledge_in(interrupt_acknowledge), .addr_in(lo[7:0]), .wdata_in(dout), .drive_in(doe),
      .delay_in(dly), .vector_in(vec), .ack_n_out(ack_n), .lines_out(dlines));

   // Earlier variant on the same pins; only its drive enables and status are watched
   cpu_bus_status #(.ENHANCED(0)) early_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .BUS_REQ_IN(req),
      .BUS_READY_OUT(), .BUS_DONE_OUT(), .BUS_RDATA_OUT(), .CORE_CTL_IN(ctl),
      .ALU_UPD_IN(alu), .REG_ACC_IN(racc), .REG_RDATA_OUT(), .PSU_OUT(psu0),
      .PSL_OUT(), .FETCH_PTR_OUT(), .INTR_TAKE_OUT(), .STALL_OUT(),
      .LOW_ADDRESS_LINES_OUT(), .LOW_ADDRESS_OE_OUT(lo_oe0),
      .PAGE_LOW_EXT_SELECT_OUT(), .PAGE_HIGH_DATA_CTRL_OUT(),
      .PAGE_OE_OUT(), .DATA_LINES_IN(dlines), .DATA_LINES_OUT(),
      .DATA_LINES_OE_OUT(doe0), .OPERATION_REQUEST_OUT(),
      .OPERATION_ACKNOWLEDGE_N_IN(ack_n), .MEMORY_OR_IO_SELECT_OUT(),
      .READ_NOT_WRITE_OUT(), .WRITE_STROBE_OUT(), .CONTROL_OE_OUT(),
      .ADDRESS_DRIVE_ENABLE_N_IN(adr_en_n), .BUS_DRIVE_ENABLE_N_IN(bus_en_n),
      .DATA_DRIVE_ENABLE_N_IN(dat_en_n), .FINAL_CYCLE_MARKER_OUT(),
      .SERIAL_OUT_LATCH_OUT(), .SERIAL_IN_PIN_IN(sense),
      .INTERRUPT_REQUEST_N_IN(irq_n), .INTERRUPT_ACKNOWLEDGE_OUT(),
      .SUSPEND_REQUEST_N_IN(susp_n), .RUNNING_INDICATOR_OUT());

   // Free-running clock
   always #5 clk = ~clk;

   // Accepted interrupts are counted in the background so no pulse is missed
   always @(negedge clk)
      if (itake === 1'b1)
         n_take++;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // One external operation: hold the request until taken, then watch the pins
   task automatic bus_op(input logic wr, io, ext, dat, vect, lst,
      input logic [14:0] a, input logic [7:0] d, input logic [7:0] exp_rd);
      int i;
      int rises;
      int lows;
      logic seen;
      logic prev;
      logic [14:0] ex;
      logic [14:0] mk;
      rises = 0;
      lows = 0;
      seen = 1'b0;
      prev = 1'b1;
      ex = io ? (ext ? {2'b01, 5'h00, a[7:0]} : {dat, 14'h0000}) : a;
      mk = (io && ext) ? 15'h20FF : 15'h7FFF;
      @(posedge clk);
      req <= {1'b1, wr, io, ext, dat, vect, lst, a, d};
      @(negedge clk);
      for (i = 0; i < 20 && rdy !== 1'b1; i++)
         @(negedge clk);
      @(posedge clk);
      req.valid <= 1'b0;
      for (i = 0; i < 40; i++)
      begin
         @(negedge clk);
         if (done === 1'b1)
            break;
         if (operation_request && wstb && !prev)
            rises++;
         if (!wstb)
            lows++;
         prev = wstb;
         if (operation_request && !seen)
         begin
            seen = 1'b1;
            chk({page_hi, page_lo, lo} & mk, ex & mk);
            chk({mio, rnw, interrupt_acknowledge, fcm, doe, doe0}, {!io, !wr, vect, lst, wr, wr && !dat_en_n});
            if (wr)
               chk(dout, d);
         end
      end
      chk({seen, done}, 2'b11);
      chk(16'(rises), {15'h0000, wr});
      if (!wr)
         chk(16'(lows), 16'h0000);
      if (!wr)
         chk(rdata, exp_rd);
   endtask

   // One-cycle command from the core
   task automatic op(input logic [5:0] k_in, input logic [14:0] x);
      core_ctl_t c;
      c = '0;
      {c.psl_we, c.psu_we, c.pop, c.push, c.halt_exec, c.instr_end} = k_in;
      c.ret_addr = x;
      c.status_wdata = x[7:0];
      @(posedge clk);
      ctl <= c;
      @(posedge clk);
      ctl <= '0;
      @(negedge clk);
   endtask

   task automatic regw(input logic [1:0] s, input logic [7:0] d);
      @(posedge clk);
      racc <= {1'b1, s, d};
      @(posedge clk);
      racc.we <= 1'b0;
   endtask

   task automatic regr(input logic [1:0] s, input logic [7:0] d);
      @(posedge clk);
      racc.sel <= s;
      @(negedge clk);
      chk(rreg, d);
   endtask

   // Watchdog
   initial
   begin
      #400000;
      n_errors++;
      close_out();
   end

   // Main sequence
   initial
   begin
      clk = 1'b0;
      rst_b = 1'b0;
      {req, ctl, alu, racc} = '0;
      {bus_en_n, adr_en_n, dat_en_n, sense, irq_n, susp_n} = 6'h03;
      dly = 4'h0;
      vec = 8'h3C;
      {n_errors, checks_done, n_take} = '0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk({fptr, run}, 16'h0001);
      chk(program_status_upper, 16'h0020);
      chk({program_status_lower, operation_request, wstb}, {PSL_RESET, 2'b01});
      chk(psu0, 16'h0000);
      // Prompt device first, then a slow one
      for (k = 0; k < 2; k++)
      begin
         @(posedge clk);
         dly <= (k == 0) ? 4'h0 : 4'h5;
         dat_en_n <= (k == 1);
         bus_op(1, 0, 0, 0, 0, 1, 15'h6A55, 8'hA5, 8'h00);
         bus_op(0, 0, 0, 0, 0, 0, 15'h1055, 8'h00, 8'hA5);
         bus_op(1, 1, 1, 0, 0, 0, 15'h0042, 8'h5A, 8'h00);
         bus_op(1, 1, 0, 0, 0, 0, 15'h0000, 8'hC3, 8'h00);
         bus_op(0, 1, 0, 1, 0, 0, 15'h0000, 8'h00, 8'hC3);
         bus_op(0, 0, 0, 0, 1, 1, 15'h0000, 8'h00, 8'h3C);
      end
      // Bus release strap
      @(posedge clk);
      {bus_en_n, adr_en_n} <= 2'b11;
      @(negedge clk);
      chk({lo_oe, page_oe, ctl_oe, doe, lo_oe0}, 16'h0000);
      @(posedge clk);
      {bus_en_n, adr_en_n} <= 2'b00;
      @(negedge clk);
      chk({lo_oe, page_oe, ctl_oe, lo_oe0}, 16'h000F);
      // Serial pins and user flags
      @(posedge clk);
      sense <= 1'b1;
      @(negedge clk);
      chk(program_status_upper[7], 1'b1);
      op(K_UP, 15'h0058);
      chk({program_status_upper, sol}, {8'hD8, 1'b1});
      chk(psu0, 16'h00C0);
      // Return stack wraps after eight calls
      for (k = 0; k < 8; k++)
         op(K_PUSH, 15'h1000 + 15'(k));
      chk(program_status_upper[2:0], 3'h0);
      for (k = 7; k > 5; k--)
      begin
         op(K_POP, 15'h0000);
         repeat (2) @(negedge clk);
         chk(fptr, 15'h1000 + 15'(k));
      end
      chk(program_status_upper[2:0], 3'h6);
      // Push straight into a pop: the fresh return address comes back
      @(posedge clk);
      ctl.push <= 1'b1;
      ctl.ret_addr <= 15'h2345;
      @(posedge clk);
      ctl.push <= 1'b0;
      ctl.pop <= 1'b1;
      @(posedge clk);
      ctl.pop <= 1'b0;
      repeat (2) @(negedge clk);
      chk(fptr, 15'h2345);
      // Register banks
      regw(2'h1, 8'h11);
      regw(2'h0, 8'h22);
      op(K_LO, 15'h0010);
      regw(2'h1, 8'h33);
      regr(2'h1, 8'h33);
      regr(2'h0, 8'h22);
      op(K_LO, 15'h000A);
      chk(program_status_lower, 16'h000A);
      regr(2'h1, 8'h11);
      // Flag updates: positive, zero, negative results
      for (k = 0; k < 3; k++)
      begin
         @(posedge clk);
         alu <= {1'b1, k == 0, k == 1, k == 2, (k == 0) ? 8'h05 : {k == 2, 7'h00}};
         @(posedge clk);
         alu.we <= 1'b0;
         @(negedge clk);
         chk(program_status_lower & 8'hE5, {(k == 0) ? CC_POSITIVE : ((k == 1) ? CC_ZERO : CC_NEGATIVE),
            k == 2, 2'b00, k == 1, 1'b0, k == 0});
      end
      // Interrupts, suspend and halt
      @(posedge clk);
      irq_n <= 1'b0;
      op(K_UP, 15'h0020);
      op(K_END, 15'h0000);
      chk(16'(n_take), 16'h0000);
      @(posedge clk);
      irq_n <= 1'b1;
      op(K_UP, 15'h0000);
      @(posedge clk);
      susp_n <= 1'b0;
      op(K_END, 15'h0000);
      chk({run, stall}, 2'b01);
      @(posedge clk);
      irq_n <= 1'b0;
      repeat (3) @(negedge clk);
      @(posedge clk);
      susp_n <= 1'b1;
      repeat (3) @(negedge clk);
      chk({14'(n_take), run, stall}, 16'h0002);
      op(K_END, 15'h0000);
      repeat (2) @(negedge clk);
      chk({15'(n_take), program_status_upper[5]}, 16'h0003);
      @(posedge clk);
      irq_n <= 1'b1;
      op(K_UP, 15'h0000);
      op(K_HALT, 15'h0000);
      chk({run, stall}, 2'b01);
      @(posedge clk);
      irq_n <= 1'b0;
      repeat (4) @(negedge clk);
      chk({14'(n_take), run, stall}, 16'h000A);
      close_out();
   end
endmodule
